// ---- common/dmes_consts.svh ----
// constants shared by both ends of the dual mode serial memory link
`ifndef DMES_CONSTS_SVH
`define DMES_CONSTS_SVH
// slave address, arbitrary value
`define DMES_DEV_ADDR 7'h3a
`define DMES_WD_PULSES 128
`define DMES_STREAM_START 7'h00
`define DMES_FUSE_LOC 7'h7f
`define DMES_PAGE_BYTES 8
`define DMES_MEM_BYTES 128
`define DMES_MEM_RESET 8'hff
`define DMES_MCLK_NS 10
`define DMES_TWR_MS 10
`define DMES_TWR_CYC (`DMES_TWR_MS * 1000000 / `DMES_MCLK_NS)
`define DMES_SCL_PERIOD_NS 10000
`define DMES_SCL_QTR_CYC (`DMES_SCL_PERIOD_NS / (4 * `DMES_MCLK_NS))
`endif

// ---- common/dmes_pkg.sv ----
// types shared by both ends of the dual mode serial memory link
package dmes_pkg;
  typedef enum logic [1:0] {
    MD_STREAM = 2'b00,
    MD_TRANS = 2'b01,
    MD_BIDIR = 2'b10
  } dmes_mode_t;
  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_RX = 3'b001,
    SL_ACK = 3'b010,
    SL_TX = 3'b011,
    SL_MACK = 3'b100
  } dmes_slv_st_t;
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP = 2'b01,
    OP_WRITE = 2'b10,
    OP_READ = 2'b11
  } dmes_op_t;
  typedef enum logic {
    H_IDLE = 1'b0,
    H_RUN = 1'b1
  } dmes_hst_t;
endpackage

// ---- common/dmes_if.sv ----
// two-wire link between bus master and memory slave
`timescale 1ns/1ps
interface dmes_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic stream_clk;
  logic sda;
  // open drain data line with pull-up
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (
    input scl,
    input sda,
    input stream_clk,
    output dev_sda_o,
    output dev_sda_oe
  );
  modport host (
    output scl,
    input sda,
    output host_sda_o,
    output host_sda_oe
  );
endinterface

// ---- rtl/dmes_host.sv ----
// bus master end: start, stop, byte write and byte read engine
`timescale 1ns/1ps
`include "dmes_consts.svh"
module dmes_host #(
  parameter int QTR_CYCLES = `DMES_SCL_QTR_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  dmes_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dmes_pkg::dmes_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_mack,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  import dmes_pkg::*;

  dmes_hst_t st_reg;
  dmes_op_t op_reg;
  logic [15:0] qcnt_reg;
  logic [1:0] ph_reg;
  logic [3:0] bit_reg;
  logic [8:0] tx_reg;
  logic [8:0] rx_reg;
  logic scl_reg;
  logic oe_reg;
  logic [1:0] sda_sync_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_data_reg;
  logic rsp_ack_reg;
  logic tick;

  assign tick = qcnt_reg == 16'(QTR_CYCLES - 1);
  assign cmd_ready = st_reg == H_IDLE;
  assign bus.scl = scl_reg;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = oe_reg;
  assign rsp_valid = rsp_valid_reg;
  assign rsp_data = rsp_data_reg;
  assign rsp_ack = rsp_ack_reg;

  // ==========================================================
  // data line synchroniser
  always_ff @(posedge mclk) begin
    if (srst) begin
      sda_sync_reg <= 2'b11;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
    end
  end

  // ==========================================================
  // quarter period divider for the serial clock
  always_ff @(posedge mclk) begin
    if (srst || st_reg == H_IDLE || tick) begin
      qcnt_reg <= 16'h0000;
    end else begin
      qcnt_reg <= qcnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // line sequencer
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= H_IDLE;
      op_reg <= OP_STOP;
      ph_reg <= 2'd0;
      bit_reg <= 4'h0;
      tx_reg <= 9'h1ff;
      rx_reg <= 9'h000;
      scl_reg <= 1'b1;
      oe_reg <= 1'b0;
      rsp_valid_reg <= 1'b0;
      rsp_data_reg <= 8'h00;
      rsp_ack_reg <= 1'b0;
    end else begin
      rsp_valid_reg <= 1'b0;
      case (st_reg)
        H_IDLE: begin
          if (cmd_valid) begin
            st_reg <= H_RUN;
            op_reg <= cmd_op;
            ph_reg <= 2'd0;
            bit_reg <= 4'h0;
            // ninth slot: released for slave ack, or driven low for master ack
            if (cmd_op == OP_READ) begin
              tx_reg <= {8'hff, !cmd_mack};
            end else begin
              tx_reg <= {cmd_data, 1'b1};
            end
          end
        end
        H_RUN: begin
          if (tick) begin
            ph_reg <= ph_reg + 2'd1;
            case (op_reg)
              OP_START: begin
                case (ph_reg)
                  2'd0: oe_reg <= 1'b0;
                  2'd1: scl_reg <= 1'b1;
                  2'd2: oe_reg <= 1'b1; // sda falls, scl high
                  default: begin
                    scl_reg <= 1'b0;
                    st_reg <= H_IDLE;
                    rsp_valid_reg <= 1'b1;
                  end
                endcase
              end
              OP_STOP: begin
                case (ph_reg)
                  2'd0: oe_reg <= 1'b1;
                  2'd1: scl_reg <= 1'b1;
                  2'd2: oe_reg <= 1'b0; // sda rises, scl high
                  default: begin
                    st_reg <= H_IDLE;
                    rsp_valid_reg <= 1'b1;
                  end
                endcase
              end
              default: begin
                case (ph_reg)
                  2'd0: oe_reg <= !tx_reg[8]; // change only while low
                  2'd1: scl_reg <= 1'b1; // master clocks, ack pulse too
                  2'd2: rx_reg <= {rx_reg[7:0], sda_sync_reg[1]};
                  default: begin
                    scl_reg <= 1'b0;
                    tx_reg <= {tx_reg[7:0], 1'b1};
                    bit_reg <= bit_reg + 4'h1;
                    if (bit_reg == 4'h8) begin
                      st_reg <= H_IDLE;
                      rsp_valid_reg <= 1'b1;
                      rsp_data_reg <= rx_reg[8:1];
                      rsp_ack_reg <= !rx_reg[0];
                    end
                  end
                endcase
              end
            endcase
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/dmes_device.sv ----
// memory slave end: mode control, two-wire slave, page write, array
`timescale 1ns/1ps
`include "dmes_consts.svh"
module dmes_device #(
  parameter logic [6:0] DEV_ADDR = `DMES_DEV_ADDR,
  parameter int WRITE_CYCLES = `DMES_TWR_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  dmes_if.dev bus,
  input wire logic wp_n,
  output dmes_pkg::dmes_mode_t mode,
  output logic busy,
  output logic fuse,
  output logic stream_restart
);
  import dmes_pkg::*;

  dmes_mode_t mode_reg;
  dmes_slv_st_t st_reg;
  logic [3:0] in_meta_reg;
  logic [3:0] in_sync_reg;
  logic [3:0] in_prev_reg;
  logic scl_s;
  logic sda_s;
  logic vlev_s;
  logic wp_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic scl_tgl_reg;
  logic [2:0] wd_m_reg;
  logic wd_fire;
  logic [1:0] rst_v_reg;
  logic [1:0] trans_v_reg;
  logic [2:0] clr_v_reg;
  logic [7:0] wd_cnt_reg;
  logic wd_tgl_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic [1:0] idx_reg;
  logic rw_reg;
  logic mack_reg;
  logic [6:0] ptr_reg;
  logic [7:0] pg_buf_reg [`DMES_PAGE_BYTES];
  logic [7:0] pg_vld_reg;
  logic [3:0] pg_base_reg;
  logic wr_ok_reg;
  logic [31:0] busy_cnt_reg;
  logic busy_reg;
  logic fuse_reg;
  logic oe_reg;
  logic restart_reg;
  logic [7:0] mem_reg [`DMES_MEM_BYTES];
  logic hit_w;
  logic wr_allow_w;
  logic do_commit;

  assign mode = mode_reg;
  assign busy = busy_reg;
  assign fuse = fuse_reg;
  assign stream_restart = restart_reg;
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_reg;

  // ==========================================================
  // pin synchronisers and bus condition decode
  always_ff @(posedge mclk) begin
    if (srst) begin
      in_meta_reg <= 4'hf;
      in_sync_reg <= 4'hf;
      in_prev_reg <= 4'hf;
    end else begin
      in_meta_reg <= {bus.scl, bus.sda, bus.stream_clk, wp_n};
      in_sync_reg <= in_meta_reg;
      in_prev_reg <= in_sync_reg;
    end
  end

  assign scl_s = in_sync_reg[3];
  assign sda_s = in_sync_reg[2];
  assign vlev_s = in_sync_reg[1];
  assign wp_s = in_sync_reg[0];
  assign scl_rise = scl_s && !in_prev_reg[3];
  assign scl_fall = !scl_s && in_prev_reg[3];
  assign bus_start = scl_s && in_prev_reg[3] && in_prev_reg[2] && !sda_s;
  assign bus_stop = scl_s && in_prev_reg[3] && !in_prev_reg[2] && sda_s;

  // ==========================================================
  // mode control, power-up reset only
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_reg <= MD_STREAM;
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= 1'b0;
      case (mode_reg)
        MD_STREAM: begin
          if (scl_fall) begin
            mode_reg <= MD_TRANS;
          end
        end
        MD_TRANS: begin
          if (hit_w) begin
            mode_reg <= MD_BIDIR;
          end else if (wd_fire && scl_s) begin
            mode_reg <= MD_STREAM;
            restart_reg <= 1'b1;
          end
        end
        MD_BIDIR: mode_reg <= MD_BIDIR; // only power loss leaves
        default: mode_reg <= MD_STREAM;
      endcase
    end
  end

  // scl fall events toward the stream clock domain
  always_ff @(posedge mclk) begin
    if (srst) begin
      scl_tgl_reg <= 1'b0;
      wd_m_reg <= 3'b000;
    end else begin
      if (scl_fall) begin
        scl_tgl_reg <= !scl_tgl_reg;
      end
      wd_m_reg <= {wd_m_reg[1:0], wd_tgl_reg};
    end
  end

  assign wd_fire = wd_m_reg[2] != wd_m_reg[1];

  // ==========================================================
  // transition watchdog on the stream clock
  always_ff @(posedge bus.stream_clk) begin
    rst_v_reg <= {rst_v_reg[0], srst};
    // bit 0 of the mode is set only in transition
    trans_v_reg <= {trans_v_reg[0], mode_reg[0]};
    clr_v_reg <= {clr_v_reg[1:0], scl_tgl_reg};
  end

  always_ff @(posedge bus.stream_clk) begin
    if (rst_v_reg[1]) begin
      wd_cnt_reg <= 8'h00;
      wd_tgl_reg <= 1'b0;
    end else if (!trans_v_reg[1]) begin
      wd_cnt_reg <= 8'h00; // not counted outside transition
    end else if (clr_v_reg[2] != clr_v_reg[1]) begin
      wd_cnt_reg <= 8'h00;
    end else if (wd_cnt_reg == 8'(`DMES_WD_PULSES - 1)) begin
      wd_cnt_reg <= 8'h00;
      wd_tgl_reg <= !wd_tgl_reg;
    end else begin
      wd_cnt_reg <= wd_cnt_reg + 8'h01;
    end
  end

  // ==========================================================
  // two-wire slave engine
  assign hit_w = st_reg == SL_RX && scl_fall && bit_cnt_reg == 4'h8 &&
                 idx_reg == 2'd0 && sh_reg[7:1] == DEV_ADDR;
  assign wr_allow_w = wr_ok_reg && !(fuse_reg && !wp_s);
  assign do_commit = bus_stop && st_reg != SL_IDLE && !rw_reg &&
                     idx_reg == 2'd2 && pg_vld_reg != 8'h00 &&
                     wr_allow_w && !busy_reg;

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_reg <= SL_IDLE;
      bit_cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      idx_reg <= 2'd0;
      rw_reg <= 1'b0;
      mack_reg <= 1'b0;
      ptr_reg <= `DMES_STREAM_START;
      pg_vld_reg <= 8'h00;
      pg_base_reg <= 4'h0;
    end else if (wd_fire && mode_reg == MD_TRANS && scl_s) begin
      st_reg <= SL_IDLE;
      ptr_reg <= `DMES_STREAM_START;
    end else if (bus_start) begin
      st_reg <= SL_RX;
      bit_cnt_reg <= 4'h0;
      idx_reg <= 2'd0;
    end else if (bus_stop) begin
      st_reg <= SL_IDLE;
      pg_vld_reg <= 8'h00;
    end else begin
      case (st_reg)
        SL_RX: begin
          if (scl_rise) begin
            sh_reg <= {sh_reg[6:0], sda_s}; // sampled scl high
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == 4'h8) begin
            bit_cnt_reg <= 4'h0;
            st_reg <= SL_ACK;
            case (idx_reg)
              2'd0: begin
                rw_reg <= sh_reg[0];
                if (!hit_w || busy_reg) begin
                  st_reg <= SL_IDLE;
                end
              end
              2'd1: begin
                ptr_reg <= sh_reg[6:0];
                pg_base_reg <= sh_reg[6:3];
                pg_vld_reg <= 8'h00;
              end
              default: begin
                pg_buf_reg[ptr_reg[2:0]] <= sh_reg;
                pg_vld_reg[ptr_reg[2:0]] <= 1'b1;
                ptr_reg[2:0] <= ptr_reg[2:0] + 3'd1;
              end
            endcase
          end
        end
        SL_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              st_reg <= SL_TX;
              sh_reg <= mem_reg[ptr_reg];
            end else begin
              st_reg <= SL_RX;
              if (idx_reg != 2'd2) begin
                idx_reg <= idx_reg + 2'd1;
              end
            end
          end
        end
        SL_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              st_reg <= SL_MACK;
              bit_cnt_reg <= 4'h0;
              ptr_reg <= ptr_reg + 7'h01;
            end else begin
              sh_reg <= {sh_reg[6:0], 1'b1};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        SL_MACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              st_reg <= SL_TX;
              sh_reg <= mem_reg[ptr_reg];
            end else begin
              st_reg <= SL_IDLE;
            end
          end
        end
        default: st_reg <= SL_IDLE;
      endcase
    end
  end

  // open drain data drive: ack slot and read zeros
  always_ff @(posedge mclk) begin
    if (srst) begin
      oe_reg <= 1'b0;
    end else begin
      oe_reg <= st_reg == SL_ACK || (st_reg == SL_TX && !sh_reg[7]);
    end
  end

  // stream input must stay high through the transfer
  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ok_reg <= 1'b0;
    end else if (bus_start) begin
      wr_ok_reg <= vlev_s;
    end else if (!vlev_s && st_reg != SL_IDLE) begin
      wr_ok_reg <= 1'b0;
    end
  end

  // ==========================================================
  // self-timed program cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_cnt_reg <= 32'h0000_0000;
      busy_reg <= 1'b0;
      fuse_reg <= 1'b0;
    end else begin
      if (do_commit) begin
        busy_cnt_reg <= 32'(WRITE_CYCLES);
        busy_reg <= 1'b1;
        if (pg_base_reg == 4'(`DMES_FUSE_LOC >> 3) && pg_vld_reg[7]) begin
          fuse_reg <= 1'b1;
        end
      end else if (busy_cnt_reg > 32'h0000_0001) begin
        busy_cnt_reg <= busy_cnt_reg - 32'h0000_0001;
      end else begin
        busy_cnt_reg <= 32'h0000_0000;
        busy_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // array, written from the page buffer at stop
  for (genvar i = 0; i < `DMES_MEM_BYTES; i++) begin : g_mem
    localparam logic [6:0] LOC = 7'(i);
    always_ff @(posedge mclk) begin
      if (srst) begin
        mem_reg[i] <= `DMES_MEM_RESET;
      end else if (do_commit && pg_base_reg == LOC[6:3] &&
                   pg_vld_reg[LOC[2:0]]) begin
        mem_reg[i] <= pg_buf_reg[LOC[2:0]];
      end
    end
  end
endmodule

// ---- dv/dmes_monitor.sv ----
// checker on the two-wire link and device status
`timescale 1ns/1ps
`include "dmes_consts.svh"
module dmes_monitor #(
  parameter int WRITE_CYCLES = `DMES_TWR_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire dmes_pkg::dmes_mode_t mode,
  input wire logic busy,
  input wire logic stream_restart
);
  import dmes_pkg::*;
  localparam int BUSY_LO = WRITE_CYCLES - 2;
  localparam int BUSY_HI = WRITE_CYCLES + 1;
  logic [31:0] busy_cnt_reg;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========================================
  // busy length counter
  always_ff @(posedge mclk) begin
    if (srst || !busy) begin
      busy_cnt_reg <= 32'h0;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
    end
  end
  // ==========================================
  // assertions
  a_no_ack_busy: assert property (busy |-> !dev_sda_oe)
    else $error("device drives sda while busy");
  a_quiet_stream: assert property
      (mode == MD_STREAM |-> !dev_sda_oe)
    else $error("device drives sda in stream mode");
  a_bidir_locked: assert property
      ($past(mode) == MD_BIDIR |-> mode == MD_BIDIR)
    else $error("left bidirectional mode");
  a_restart_mode: assert property
      (stream_restart |-> ##[0:2] mode == MD_STREAM)
    else $error("restart without stream mode");
  a_trans_entry: assert property
      ($past(mode) == MD_STREAM && mode != MD_STREAM
      |-> mode == MD_TRANS && !scl)
    else $error("bad exit from stream mode");
  a_dev_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device sda changed with scl high");
  a_start_idle: assert property
      ($rose(host_sda_oe) && scl |-> $past(sda))
    else $error("start not from high sda");
  a_busy_stop: assert property ($rose(busy) |-> scl && sda)
    else $error("program cycle without stop");
  a_busy_length: assert property
      ($fell(busy) |-> busy_cnt_reg >= BUSY_LO && busy_cnt_reg <= BUSY_HI)
    else $error("program cycle length wrong");
endmodule

// ---- dv/dual_mode_eeprom_serial_slave_test.sv ----
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`include "dmes_consts.svh"
module dual_mode_eeprom_serial_slave_test;
  import dmes_pkg::*;
  localparam int QTR = 8;
  localparam int WCYC = 600;
  localparam logic [6:0] ADDR = `DMES_DEV_ADDR;
  logic mclk, srst, stream_osc, stream_on, stream_lvl, wp_n;
  logic cmd_valid, cmd_ready, cmd_mack, rsp_valid, rsp_ack;
  logic busy, fuse, stream_restart;
  logic [7:0] cmd_data, rsp_data;
  dmes_op_t cmd_op;
  dmes_mode_t mode;
  int errors, n_compared, gap;
  dmes_if link();
  // stream input: free pulses, or a held level while stream_on is low
  assign link.stream_clk = stream_on ? stream_osc : stream_lvl;
  dmes_host #(.QTR_CYCLES(QTR)) u_dmes_host (.mclk(mclk), .srst(srst),
    .bus(link), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_mack(cmd_mack),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  dmes_device #(.DEV_ADDR(ADDR), .WRITE_CYCLES(WCYC)) u_dmes_device (
    .mclk(mclk), .srst(srst), .bus(link), .wp_n(wp_n), .mode(mode),
    .busy(busy), .fuse(fuse), .stream_restart(stream_restart));
  dmes_monitor #(.WRITE_CYCLES(WCYC)) u_dmes_monitor (.mclk(mclk),
    .srst(srst), .scl(link.scl), .sda(link.sda),
    .host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe),
    .mode(mode), .busy(busy), .stream_restart(stream_restart));
  // ==========================================
  // clocks
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    stream_osc = 1'b0;
    #3;
    forever #15 stream_osc = ~stream_osc;
  end
  // ==========================================
  // tasks
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic op(input dmes_op_t o, input logic [7:0] d, input logic m);
    int i;
    cmd_op = o;
    cmd_data = d;
    cmd_mack = m;
    cmd_valid = 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    check("ready", {7'h0, cmd_ready}, 8'h00);
    for (i = 0; i < 400; i++) begin
      if (rsp_valid === 1'b1) break;
      @(negedge mclk);
    end
    if (i == 400) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic wr_byte(input logic [7:0] d, input logic exp_ack);
    op(OP_WRITE, d, 1'b0);
    check("echo", rsp_data, d);
    check("ack", {7'h0, rsp_ack}, {7'h0, exp_ack});
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2 * WCYC; i++) begin
      if (busy === 1'b0) break;
      @(negedge mclk);
    end
    if (i == 2 * WCYC) begin
      errors++;
      complete_run();
    end
  endtask
  task automatic wr_at(input logic [7:0] w, input int n,
                       input logic [7:0] d0, d1, d2);
    wait_idle();
    op(OP_START, 8'h00, 1'b0);
    wr_byte({ADDR, 1'b0}, 1'b1);
    wr_byte(w, 1'b1);
    wr_byte(d0, 1'b1);
    if (n > 1) wr_byte(d1, 1'b1);
    if (n > 2) wr_byte(d2, 1'b1);
    op(OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic rd_at(input logic [7:0] w, input logic [7:0] e0, e1);
    wait_idle();
    op(OP_START, 8'h00, 1'b0);
    wr_byte({ADDR, 1'b0}, 1'b1);
    wr_byte(w, 1'b1);
    op(OP_START, 8'h00, 1'b0);
    wr_byte({ADDR, 1'b1}, 1'b1);
    op(OP_READ, 8'h00, 1'b1);
    check("read", rsp_data, e0);
    op(OP_READ, 8'h00, 1'b0);
    check("read", rsp_data, e1);
    op(OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic poll(input logic exp_ack);
    op(OP_START, 8'h00, 1'b0);
    wr_byte({ADDR, 1'b0}, exp_ack);
    op(OP_STOP, 8'h00, 1'b0);
  endtask
  // ==========================================
  // main sequence
  initial begin
    srst = 1'b1;
    stream_on = 1'b1;
    stream_lvl = 1'b1;
    wp_n = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_START;
    cmd_data = 8'h00;
    cmd_mack = 1'b0;
    errors = 0;
    n_compared = 0;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    check("mode", 8'(mode), 8'(MD_STREAM));
    check("busy", {7'h0, busy}, 8'h00);
    $display("test reset done");
    op(OP_START, 8'h00, 1'b0);
    repeat (4) @(negedge mclk);
    check("mode", 8'(mode), 8'(MD_TRANS));
    wr_byte({ADDR ^ 7'h01, 1'b0}, 1'b0);
    op(OP_STOP, 8'h00, 1'b0);
    check("mode", 8'(mode), 8'(MD_TRANS));
    for (gap = 0; gap < 1000; gap++) begin
      if (stream_restart === 1'b1) break;
      @(negedge mclk);
    end
    check("gap", 8'(gap >= 300 && gap <= 400), 8'h01);
    @(negedge mclk);
    check("mode", 8'(mode), 8'(MD_STREAM));
    $display("test watchdog done");
    stream_on = 1'b0;
    wr_at(8'h05, 1, 8'ha5, 8'h00, 8'h00);
    check("mode", 8'(mode), 8'(MD_BIDIR));
    poll(1'b0);
    check("busy", {7'h0, busy}, 8'h01);
    wait_idle();
    poll(1'b1);
    rd_at(8'h05, 8'ha5, 8'hff);
    $display("test byte write done");
    wr_at(8'h0e, 3, 8'h11, 8'h22, 8'h33);
    rd_at(8'h0e, 8'h11, 8'h22);
    rd_at(8'h08, 8'h33, 8'hff);
    $display("test page wrap done");
    stream_lvl = 1'b0;
    wr_at(8'h20, 1, 8'h77, 8'h00, 8'h00);
    stream_lvl = 1'b1;
    repeat (8) @(negedge mclk);
    check("busy", {7'h0, busy}, 8'h00);
    rd_at(8'h20, 8'hff, 8'hff);
    stream_on = 1'b1;
    repeat (500) @(negedge mclk);
    stream_on = 1'b0;
    check("mode", 8'(mode), 8'(MD_BIDIR));
    $display("test stream low done");
    wr_at(8'h7f, 1, 8'h5a, 8'h00, 8'h00);
    stream_lvl = 1'b0;
    wait_idle();
    stream_lvl = 1'b1;
    check("fuse", {7'h0, fuse}, 8'h01);
    rd_at(8'h7f, 8'h5a, 8'hff);
    wp_n = 1'b0;
    wr_at(8'h7e, 1, 8'h44, 8'h00, 8'h00);
    repeat (8) @(negedge mclk);
    check("busy", {7'h0, busy}, 8'h00);
    wp_n = 1'b1;
    rd_at(8'h7e, 8'hff, 8'h5a);
    $display("test protect done");
    complete_run();
  end
endmodule
